// ==== hdl/pmf_flow_unit.sv ====
// program flow unit: fetch counter, jump/call/return, table read, glyph port
// assumes a single clock; the pointer register and interrupt requests come
// from outside and are synchronous; one instruction per cycle in steady state
`timescale 1ns/1ps

// How it works
// - store covers words 000 to F7F only
// - lower page to 7FF, upper from 800
// - upper page readable as glyphs, still executable
// - words 000 to 0FF reached indirectly
// - one instruction per 16-bit word
// - core can never write the store
// - start at zero, step by one
// - accepted interrupt loads its vector
// - direct jump: opcode lsb plus 11 bits
// - indirect jump target from 8-bit pointer
// - opcode 0C lower page, 0D upper page
// - word split into 1,4,3,4,4 bit fields
// - direct call reaches lower page only
// - return resumes after call; skip variant nops
// - calls and returns work in both pages
// - indirect call entry from 8-bit pointer
// - table read moves whole word to buffer
// - table read borrows one stack level
// - 12-bit fetch counter, steps or loads
// - vectors 4,3,2,1 by fixed priority
// - stack keeps counter plus one; return reloads
// - buffer nibbles 0C-0F, msb nibble lowest
module pmf_flow_unit (
  input  wire logic        clk,               // 50 MHz clock
  input  wire logic        reset_n,           // async reset, low
  input  wire logic [7:0]  pointer_register,  // indirect / table pointer
  input  wire logic [3:0]  irq_req,           // pin, timer, vsync, serial
  input  wire logic        skip_in,           // current instr met its skip test
  input  wire logic        glyph_req,         // display unit read request
  input  wire logic [10:0] glyph_offset,      // word offset into upper page
  input  wire logic        load_we,           // mask load strobe
  input  wire logic [11:0] load_addr,         // mask load address
  input  wire logic [15:0] load_data,         // mask load word
  output logic      [11:0] fetch_counter,     // address of instr_word
  output logic      [15:0] instr_word,        // word being executed
  output logic             instr_valid,       // instr_word is to be executed
  output logic             irq_ack,           // interrupt accepted this cycle
  output logic      [11:0] irq_vector,        // vector of accepted interrupt
  output logic             table_buffer_we,   // table word valid, write buffer
  output logic      [15:0] table_buffer_data, // [15:12] to nibble 0C
  output logic      [15:0] glyph_data,        // glyph word
  output logic             glyph_valid,       // glyph_data answers last request
  output logic      [2:0]  stack_depth        // used stack levels
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pmf_pkg::pmf_state_e state_reg, state_next;
  logic [11:0] pc_reg, pc_next, rd_addr;
  logic        skip_reg, skip_next;
  logic        glyph_valid_reg;
  logic [15:0] word;

  pmf_stack_if stk ();

  pmf_stack u_stack (
    .clk     (clk),
    .reset_n (reset_n),
    .stk     (stk)
  );

  // ---------------------------------------------------------------
  // store
  // ---------------------------------------------------------------
  // bit 11 set marks the upper page
  // display reads from the upper page on its own port
  wire [11:0] glyph_addr = pmf_pkg::PAGE1_BASE + {1'b0, glyph_offset};

  pmf_store u_store (
    .clk       (clk),
    .reset_n   (reset_n),
    .rd_a_addr (rd_addr),
    .rd_a_data (word),
    .rd_b_addr (glyph_addr),
    .rd_b_data (glyph_data),
    .load_we   (load_we),
    .load_addr (load_addr),
    .load_data (load_data)
  );

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire in_fill  = state_reg == pmf_pkg::ST_FILL;
  wire in_exec  = state_reg == pmf_pkg::ST_EXEC;
  wire in_table = state_reg == pmf_pkg::ST_TABLE;
  // a skipped word is not executed
  wire is_exec  = in_exec && !skip_reg;
  // fields taken by the package helpers
  wire [4:0] op  = pmf_pkg::op_of(word);
  wire [3:0] sub = pmf_pkg::sub_of(word);
  wire flow_grp  = is_exec && (op == pmf_pkg::OP_FLOW);
  // two jump opcodes select the page
  wire dj        = is_exec && (op == pmf_pkg::OP_JUMP_LO || op == pmf_pkg::OP_JUMP_HI);
  wire d_call    = is_exec && (op == pmf_pkg::OP_CALL);
  wire ret       = flow_grp && (sub == pmf_pkg::SUB_RET);
  wire return_and_skip     = flow_grp && (sub == pmf_pkg::SUB_RETURN_AND_SKIP);
  wire jind      = flow_grp && (sub == pmf_pkg::SUB_JMP_IND);
  wire cind      = flow_grp && (sub == pmf_pkg::SUB_CAL_IND);
  wire tread     = flow_grp && (sub == pmf_pkg::SUB_TABLE);
  wire flow_chg  = dj || d_call || ret || return_and_skip || jind || cind || tread;

  // ---------------------------------------------------------------
  // targets
  // ---------------------------------------------------------------
  // opcode lsb on top of the 11-bit operand
  wire [11:0] dj_target   = {word[11], word[10:0]};
  // call operand has no page bit
  wire [11:0] call_target = {1'b0, word[10:0]};
  wire [11:0] ind_target  = {4'h0, pointer_register};
  // wraps past the top so stepping never leaves the store; a direct jump with opcode 0D can still reach F80 to FFF
  wire [11:0] pc_inc = (pc_reg == pmf_pkg::LAST_ADDR) ? pmf_pkg::RESET_ADDR
                                                      : pc_reg + 12'h001;

  function automatic logic [11:0] vec_of(input logic [3:0] r);
    if (r[3]) begin
      return pmf_pkg::VEC_PIN;
    end else if (r[2]) begin
      return pmf_pkg::VEC_TIMER;
    end else if (r[1]) begin
      return pmf_pkg::VEC_VSYNC;
    end else if (r[0]) begin
      return pmf_pkg::VEC_SERIAL;
    end
    return pmf_pkg::VEC_NONE;
  endfunction

  // taken only on a plain word so its own flow change is not lost
  // a word meeting its skip test also waits, else the vector word would be blanked
  wire        irq_take = is_exec && !flow_chg && !skip_in && (irq_req != 4'h0);
  wire [11:0] irq_vec  = vec_of(irq_req);

  // ---------------------------------------------------------------
  // next fetch address
  // ---------------------------------------------------------------
  // step unless a flow change or interrupt loads the counter; fill and the table read word hold it, the table cycle steps
  always_comb begin
    pc_next = pc_inc;
    unique case (state_reg)
      pmf_pkg::ST_FILL:  pc_next = pc_reg;
      pmf_pkg::ST_TABLE: pc_next = pc_inc;
      pmf_pkg::ST_EXEC: begin
        if (tread) begin
          pc_next = pc_reg;
        end else if (irq_take) begin
          pc_next = irq_vec;
        end else if (dj) begin
          pc_next = dj_target;
        end else if (d_call) begin
          pc_next = call_target;
        end else if (jind || cind) begin
          pc_next = ind_target;
        end else if (ret || return_and_skip) begin
          pc_next = stk.top_addr;
        end
      end
    endcase
  end

  // table read borrows the fetch port for one cycle
  assign rd_addr = tread ? ind_target : pc_next;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      pmf_pkg::ST_FILL:  state_next = pmf_pkg::ST_EXEC;
      pmf_pkg::ST_EXEC:  state_next = tread ? pmf_pkg::ST_TABLE : pmf_pkg::ST_EXEC;
      pmf_pkg::ST_TABLE: state_next = pmf_pkg::ST_EXEC;
      default:           state_next = pmf_pkg::ST_FILL;
    endcase
  end

  // return-and-skip or a met skip test blanks the next word
  assign skip_next = in_exec ? (return_and_skip || (is_exec && skip_in && !flow_chg)) : skip_reg;

  // ---------------------------------------------------------------
  // stack link
  // ---------------------------------------------------------------
  // return address is counter plus one
  // table read holds one level until its word lands
  // limitation: a table read with all six levels used pops a live entry
  assign stk.push      = d_call || cind || irq_take || tread;
  assign stk.pop       = ret || return_and_skip || in_table;
  assign stk.push_addr = pc_inc;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= pmf_pkg::ST_FILL;
      pc_reg    <= pmf_pkg::RESET_ADDR;
      skip_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      pc_reg    <= pc_next;
      skip_reg  <= skip_next;
    end
  end

  // glyph word lags its request by one cycle, like the store itself
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      glyph_valid_reg <= 1'b0;
    end else begin
      glyph_valid_reg <= glyph_req;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign fetch_counter     = pc_reg;
  assign instr_word        = word;
  assign instr_valid       = is_exec;
  assign irq_ack           = irq_take;
  assign irq_vector        = irq_take ? irq_vec : pmf_pkg::VEC_NONE;
  // whole word, top nibble bound for 0C
  assign table_buffer_we   = in_table;
  assign table_buffer_data = word;
  assign glyph_valid       = glyph_valid_reg;
  assign stack_depth       = stk.depth;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_fill_at_zero: assert property (in_fill |-> pc_reg == pmf_pkg::RESET_ADDR)
    else $error("fill state away from address zero");
  a_plain_step: assert property (
    is_exec && !flow_chg && !irq_take |=> pc_reg == $past(pc_inc))
    else $error("plain word did not advance counter by one");
  a_irq_pin_vec: assert property (
    irq_take && irq_req[3] |=> pc_reg == 12'h004)
    else $error("pin interrupt did not vector to 4");
  a_irq_serial_vec: assert property (
    irq_take && irq_req == 4'h1 |=> pc_reg == 12'h001)
    else $error("serial interrupt did not vector to 1");
  a_jump_target: assert property (dj |=> pc_reg == $past(word[11:0]))
    else $error("direct jump target wrong");
  a_jump_page: assert property (
    dj |=> pc_reg[11] == ($past(op) == pmf_pkg::OP_JUMP_HI))
    else $error("jump page does not follow opcode");
  a_call_page: assert property (d_call |=> !pc_reg[11])
    else $error("direct call left the lower page");
  a_ind_low: assert property (jind || cind |=> pc_reg[11:8] == 4'h0)
    else $error("indirect target above 0FF");
  a_call_return: assert property (
    d_call && stk.depth < 3'h6 |=> stk.top_addr == $past(pc_inc))
    else $error("call did not save counter plus one");
  a_table_seq: assert property (
    tread |=> table_buffer_we && pc_reg == $past(pc_reg) ##1 in_exec
    && pc_reg == $past(pc_reg, 2) + 12'h001)
    else $error("table read sequence broken");
  a_table_stack: assert property (
    tread && stk.depth < 3'h6 |=> stk.depth == $past(stk.depth) + 3'h1
    ##1 stk.depth == $past(stk.depth, 2))
    else $error("table read did not borrow one level");
  a_return_and_skip_nop: assert property (return_and_skip |=> !instr_valid ##1 skip_reg == 1'b0)
    else $error("word after return-and-skip executed");
  a_pc_range: assert property (pmf_pkg::in_rom(pc_reg))
    else $error("counter outside the store");
  a_irq_refused: assert property (
    irq_req != 4'h0 && (flow_chg || skip_in) |-> !irq_ack)
    else $error("interrupt taken on a flow change or skip word");
  a_irq_timer_vec: assert property (
    irq_take && irq_req[3:2] == 2'h1 |=> pc_reg == 12'h003)
    else $error("timer interrupt did not vector to 3");
  a_irq_vsync_vec: assert property (
    irq_take && irq_req[3:1] == 3'h1 |=> pc_reg == 12'h002)
    else $error("vsync interrupt did not vector to 2");
  a_irq_push: assert property (
    irq_take && stk.depth < 3'h6 |=> stk.top_addr == $past(pc_inc))
    else $error("interrupt did not save counter plus one");
  a_low_page_jump: assert property (
    dj && op == pmf_pkg::OP_JUMP_LO |=> pc_reg <= 12'h7FF)
    else $error("lower page jump left the lower page");
  a_ind_target: assert property (
    jind || cind |=> pc_reg == {4'h0, $past(pointer_register)})
    else $error("indirect target differs from pointer");
  a_ret_target: assert property (
    (ret || return_and_skip) && stk.depth != 3'h0 |=> pc_reg == $past(stk.top_addr))
    else $error("return did not resume at saved address");
  a_skip_blank: assert property (
    is_exec && skip_in && !flow_chg |=> !instr_valid)
    else $error("word after a met skip test executed");
  a_glyph_lag: assert property (glyph_req |=> glyph_valid)
    else $error("glyph word not flagged one cycle after request");
  a_cind_push: assert property (
    cind && stk.depth < 3'h6 |=> stk.depth == $past(stk.depth) + 3'h1)
    else $error("indirect call did not push");

  // ---------------------------------------------------------------
  // cover points
  // ---------------------------------------------------------------
  c_call_ret: cover property (d_call ##[1:20] ret);
  c_table:    cover property (tread ##2 is_exec);
  c_irq:      cover property (irq_take ##[1:20] ret);
  c_skip:     cover property (is_exec && skip_in && !flow_chg ##1 !instr_valid);
  c_glyph:    cover property (glyph_req ##1 glyph_valid);
endmodule

// ==== hdl/pmf_stack.sv ====
// six-level return-address stack
// a push when full and a pop when empty are ignored; software must avoid them
`timescale 1ns/1ps
module pmf_stack (
  input  wire logic clk,          // clock
  input  wire logic reset_n,      // async reset, low
  pmf_stack_if.owner stk          // push/pop link
);
  logic [11:0] entry_reg [0:5];
  logic [2:0]  depth_reg;
  wire         do_push = stk.push && (depth_reg < pmf_pkg::STACK_LEVELS);
  wire         do_pop  = stk.pop && (depth_reg != 3'h0);
  wire  [2:0]  top_idx = depth_reg - 3'h1;

  genvar i;
  generate
    for (i = 0; i < 6; i++) begin : g_lvl
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          entry_reg[i] <= 12'h000;
        end else if (do_push && depth_reg == 3'(i)) begin
          entry_reg[i] <= stk.push_addr;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      depth_reg <= 3'h0;
    end else if (do_push) begin
      depth_reg <= depth_reg + 3'h1;
    end else if (do_pop) begin
      depth_reg <= depth_reg - 3'h1;
    end
  end

  assign stk.top_addr = (depth_reg != 3'h0) ? entry_reg[top_idx] : 12'h000;
  assign stk.depth    = depth_reg;
endmodule

// ==== hdl/pmf_store.sv ====
// instruction store: 3968 x 16 words, two registered read ports
// assumes the load port is driven only by mask programming, never by the core
`timescale 1ns/1ps
module pmf_store (
  input  wire logic        clk,        // clock
  input  wire logic        reset_n,    // async reset, low
  input  wire logic [11:0] rd_a_addr,  // fetch / table address
  output logic      [15:0] rd_a_data,  // word at rd_a_addr, one cycle late
  input  wire logic [11:0] rd_b_addr,  // glyph address
  output logic      [15:0] rd_b_data,  // word at rd_b_addr, one cycle late
  input  wire logic        load_we,    // mask load strobe
  input  wire logic [11:0] load_addr,  // mask load address
  input  wire logic [15:0] load_data   // mask load word
);
  // one full instruction word per address
  logic [15:0] mem [0:pmf_pkg::ROM_WORDS-1];
  wire a_ok = pmf_pkg::in_rom(rd_a_addr);
  wire b_ok = pmf_pkg::in_rom(rd_b_addr);

  // no write path from the instruction side
  always_ff @(posedge clk) begin
    if (load_we && pmf_pkg::in_rom(load_addr)) begin
      mem[load_addr] <= load_data;
    end
  end

  // words past the top read as zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_a_data <= 16'h0000;
      rd_b_data <= 16'h0000;
    end else begin
      rd_a_data <= a_ok ? mem[rd_a_addr] : 16'h0000;
      rd_b_data <= b_ok ? mem[rd_b_addr] : 16'h0000;
    end
  end
endmodule

// ==== pkg/pmf_pkg.sv ====
// constants, state codes and word-field helpers for the program flow unit
// assumes one instruction word per fetch address and a 12-bit fetch counter
package pmf_pkg;
  // ---------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------
  localparam logic [11:0] RESET_ADDR  = 12'h000;
  localparam logic [11:0] LAST_ADDR   = 12'hF7F;
  localparam logic [11:0] PAGE1_BASE  = 12'h800;
  localparam logic [11:0] TABLE_LAST  = 12'h0FF;
  localparam logic [10:0] GLYPH_LAST  = 11'h77F;
  localparam int unsigned ROM_WORDS   = 3968;
  // interrupt vectors, highest priority first
  localparam logic [11:0] VEC_PIN     = 12'h004;
  localparam logic [11:0] VEC_TIMER   = 12'h003;
  localparam logic [11:0] VEC_VSYNC   = 12'h002;
  localparam logic [11:0] VEC_SERIAL  = 12'h001;
  localparam logic [11:0] VEC_NONE    = 12'h000;
  // ---------------------------------------------------------------
  // opcodes (upper 5 bits) and flow sub-codes (low nibble)
  // ---------------------------------------------------------------
  localparam logic [4:0]  OP_JUMP_LO  = 5'h0C;
  localparam logic [4:0]  OP_JUMP_HI  = 5'h0D;
  localparam logic [4:0]  OP_CALL     = 5'h1D;
  localparam logic [4:0]  OP_FLOW     = 5'h0E;
  localparam logic [3:0]  SUB_RET     = 4'h0;
  localparam logic [3:0]  SUB_RETURN_AND_SKIP   = 4'h1;
  localparam logic [3:0]  SUB_JMP_IND = 4'h2;
  localparam logic [3:0]  SUB_CAL_IND = 4'h3;
  localparam logic [3:0]  SUB_TABLE   = 4'h4;
  // table buffer nibbles, most significant at lowest address
  localparam logic [6:0]  TBUF_NIB3   = 7'h0C;
  localparam logic [6:0]  TBUF_NIB0   = 7'h0F;
  localparam logic [2:0]  STACK_LEVELS = 3'h6;
  typedef enum logic [2:0] {
    ST_FILL  = 3'b001,
    ST_EXEC  = 3'b010,
    ST_TABLE = 3'b100
  } pmf_state_e;
  // word fields of 1,4,3,4,4 bits from the top
  function automatic logic [4:0] op_of(input logic [15:0] w);
    return w[15:11];
  endfunction
  function automatic logic [3:0] sub_of(input logic [15:0] w);
    return w[3:0];
  endfunction
  function automatic logic in_rom(input logic [11:0] a);
    return a <= LAST_ADDR;
  endfunction
endpackage

// ==== pkg/pmf_stack_if.sv ====
// return-address stack link between flow unit and stack
// assumes push and pop are never raised in the same cycle
`timescale 1ns/1ps
interface pmf_stack_if;
  logic        push;
  logic        pop;
  logic [11:0] push_addr;
  logic [11:0] top_addr;
  logic [2:0]  depth;
  modport owner (input push, input pop, input push_addr, output top_addr, output depth);
  modport user  (output push, output pop, output push_addr, input top_addr, input depth);
endinterface

// ==== test/tb.sv ====
// self-checking bench for the program flow unit top
// assumes the store keeps its words across reset and is filled only by the load port
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [7:0]  ptr;
    logic [11:0] fc;
    logic [15:0] iw;
    logic        vld;
    logic        twe;
    logic [2:0]  dep;
  } pmf_row_s;

  logic        clk;
  logic        reset_n;
  logic [7:0]  pointer_register;
  logic [3:0]  irq_req;
  logic        skip_in;
  logic        glyph_req;
  logic [10:0] glyph_offset;
  logic        load_we;
  logic [11:0] load_addr;
  logic [15:0] load_data;
  logic [11:0] fetch_counter;
  logic [15:0] instr_word;
  logic        instr_valid;
  logic        irq_ack;
  logic [11:0] irq_vector;
  logic        table_buffer_we;
  logic [15:0] table_buffer_data;
  logic [15:0] glyph_data;
  logic        glyph_valid;
  logic [2:0]  stack_depth;
  int          errors;
  int          n_tests;
  int          i;

  // ---------------------------------------------------------------
  // program image {address, word} and expected trace
  // ---------------------------------------------------------------
  logic [27:0] image [27] = '{
    28'h000_6010, 28'h001_7000, 28'h002_7000, 28'h003_7000, 28'h004_7000,
    28'h010_1111, 28'h011_E900, 28'h012_2222, 28'h013_E910, 28'h014_3333,
    28'h015_6A00, 28'h020_BEEF, 28'h030_7003, 28'h031_5555, 28'h032_0000,
    28'h033_6032, 28'h034_6032, 28'h040_7000, 28'h100_4444, 28'h101_7000,
    28'h110_7001, 28'h120_7000, 28'h900_C0DE, 28'h901_1357, 28'hA00_7004,
    28'hA01_E920, 28'hA02_7002};
  // one row per cycle from the first executed word
  pmf_row_s rows [20] = '{
    '{8'h00, 12'h000, 16'h6010, 1'b1, 1'b0, 3'h0},
    '{8'h00, 12'h010, 16'h1111, 1'b1, 1'b0, 3'h0},
    '{8'h00, 12'h011, 16'hE900, 1'b1, 1'b0, 3'h0},
    '{8'h00, 12'h100, 16'h4444, 1'b1, 1'b0, 3'h1},
    '{8'h00, 12'h101, 16'h7000, 1'b1, 1'b0, 3'h1},
    '{8'h00, 12'h012, 16'h2222, 1'b1, 1'b0, 3'h0},
    '{8'h00, 12'h013, 16'hE910, 1'b1, 1'b0, 3'h0},
    '{8'h00, 12'h110, 16'h7001, 1'b1, 1'b0, 3'h1},
    '{8'h00, 12'h014, 16'h3333, 1'b0, 1'b0, 3'h0},
    '{8'h00, 12'h015, 16'h6A00, 1'b1, 1'b0, 3'h0},
    '{8'h20, 12'hA00, 16'h7004, 1'b1, 1'b0, 3'h0},
    '{8'h20, 12'hA00, 16'hBEEF, 1'b0, 1'b1, 3'h1},
    '{8'h00, 12'hA01, 16'hE920, 1'b1, 1'b0, 3'h0},
    '{8'h00, 12'h120, 16'h7000, 1'b1, 1'b0, 3'h1},
    '{8'h30, 12'hA02, 16'h7002, 1'b1, 1'b0, 3'h0},
    '{8'h40, 12'h030, 16'h7003, 1'b1, 1'b0, 3'h0},
    '{8'h00, 12'h040, 16'h7000, 1'b1, 1'b0, 3'h1},
    '{8'h00, 12'h031, 16'h5555, 1'b1, 1'b0, 3'h0},
    '{8'h00, 12'h032, 16'h0000, 1'b1, 1'b0, 3'h0},
    '{8'h00, 12'h033, 16'h6032, 1'b1, 1'b0, 3'h0}};

  pmf_flow_unit DUT (
    .clk               (clk),
    .reset_n           (reset_n),
    .pointer_register  (pointer_register),
    .irq_req           (irq_req),
    .skip_in           (skip_in),
    .glyph_req         (glyph_req),
    .glyph_offset      (glyph_offset),
    .load_we           (load_we),
    .load_addr         (load_addr),
    .load_data         (load_data),
    .fetch_counter     (fetch_counter),
    .instr_word        (instr_word),
    .instr_valid       (instr_valid),
    .irq_ack           (irq_ack),
    .irq_vector        (irq_vector),
    .table_buffer_we   (table_buffer_we),
    .table_buffer_data (table_buffer_data),
    .glyph_data        (glyph_data),
    .glyph_valid       (glyph_valid),
    .stack_depth       (stack_depth)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // inputs always move 1 ns after the rising edge; outputs are read 14 ns later
  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic wait_fc(input logic [11:0] a);
    int k;
    k = 0;
    while (k < 60 && fetch_counter !== a) begin
      tick();
      #14;
      k++;
    end
    if (fetch_counter !== a) begin
      errors++;
      summarize();
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    errors = 0;
    n_tests = 0;
    reset_n = 1'b0;
    pointer_register = 8'h00;
    irq_req = 4'h0;
    skip_in = 1'b0;
    glyph_req = 1'b0;
    glyph_offset = 11'h000;
    load_we = 1'b0;
    load_addr = 12'h000;
    load_data = 16'h0000;
    repeat (16) @(posedge clk);
    #1;
    // store is filled with the core still held, so no unknown word ever runs
    for (i = 0; i < 27; i++) begin
      load_we = 1'b1;
      load_addr = image[i][27:16];
      load_data = image[i][15:0];
      tick();
    end
    load_we = 1'b0;
    #14;
    chk(16'(fetch_counter), 16'h0000);
    chk(16'(instr_valid), 16'h0000);
    chk(16'(stack_depth), 16'h0000);
    $display("test reset done");
    tick();
    reset_n = 1'b1;
    // first edge after release fetches word zero, which then stands
    tick();
    // jumps, calls, returns, table read cycle by cycle
    for (i = 0; i < 20; i++) begin
      pointer_register = rows[i].ptr;
      #14;
      chk(16'(fetch_counter), 16'(rows[i].fc));
      chk(instr_word, rows[i].iw);
      chk(16'(instr_valid), 16'(rows[i].vld));
      chk(16'(table_buffer_we), 16'(rows[i].twe));
      chk(16'(stack_depth), 16'(rows[i].dep));
      if (i == 11) begin
        chk(table_buffer_data, 16'hBEEF);
      end
      tick();
    end
    $display("test flow trace done");
    // priority vectors; a request on a jump word waits
    for (i = 0; i < 4; i++) begin
      #14;
      wait_fc(12'h032);
      tick();
      irq_req = 4'hF >> i;
      #14;
      chk(16'(irq_ack), 16'h0000);
      tick();
      #14;
      chk(16'(irq_ack), 16'h0001);
      chk(16'(irq_vector), 16'(4 - i));
      tick();
      irq_req = 4'h0;
      #14;
      chk(16'(fetch_counter), 16'(4 - i));
      chk(16'(stack_depth), 16'h0001);
      tick();
      #14;
      chk(16'(fetch_counter), 16'h0033);
      tick();
    end
    $display("test interrupts done");
    // skipped word becomes a nop and the count steps on
    skip_in = 1'b1;
    #14;
    chk(16'(fetch_counter), 16'h0032);
    tick();
    skip_in = 1'b0;
    #14;
    chk(16'(instr_valid), 16'h0000);
    tick();
    #14;
    chk(16'(fetch_counter), 16'h0034);
    $display("test skip done");
    // glyph reads back to back, past the last glyph word
    tick();
    glyph_req = 1'b1;
    glyph_offset = 11'h100;
    tick();
    glyph_offset = 11'h101;
    #14;
    chk(16'(glyph_valid), 16'h0001);
    chk(glyph_data, 16'hC0DE);
    tick();
    glyph_offset = 11'h780;
    #14;
    chk(glyph_data, 16'h1357);
    tick();
    glyph_req = 1'b0;
    #14;
    chk(glyph_data, 16'h0000);
    tick();
    #14;
    chk(16'(glyph_valid), 16'h0000);
    $display("test glyph done");
    // reset in mid-run restarts at word zero
    tick();
    reset_n = 1'b0;
    #14;
    chk(16'(fetch_counter), 16'h0000);
    chk(16'(instr_valid), 16'h0000);
    tick();
    reset_n = 1'b1;
    tick();
    #14;
    chk(16'(fetch_counter), 16'h0000);
    chk(instr_word, 16'h6010);
    chk(16'(instr_valid), 16'h0001);
    $display("test mid-run reset done");
    summarize();
  end
endmodule
